// *** shared/pcu_consts.svh ***
// Constants for the comparison-unit mode update block.
// Assumes: included by bare name from design files.
`ifndef PCU_CONSTS_SVH
`define PCU_CONSTS_SVH

// ------------------------------------------------------------------
// Register map
// ------------------------------------------------------------------
`define PCU_MODE_UPD_BASE   9'h13C
`define PCU_MODE_UPD_STRIDE 9'h010
`define PCU_STATUS_OFFSET   9'h1C0
`define PCU_ADDR_W          9

// ------------------------------------------------------------------
// Field positions of comparison_mode_update
// ------------------------------------------------------------------
`define PCU_EN_BIT          0
`define PCU_TRG_LSB         4
`define PCU_PER_LSB         8
`define PCU_UPR_LSB         16
`define PCU_FIELD_W         4

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PCU_FIELD_RST       4'h0
`define PCU_NUM_UNITS       8

// ------------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------------
`define PCU_RESP_OKAY       2'h0
`define PCU_RESP_SLVERR     2'h2

`endif

// *** shared/pcu_pkg.sv ***
// Types for the comparison-unit mode update block.
// Assumes: pcu_consts.svh is on the include path.
`include "pcu_consts.svh"

package pcu_pkg;
	// One four-bit setting field
	typedef logic [`PCU_FIELD_W-1:0] pcu_field_t;
	// Register bus byte address
	typedef logic [`PCU_ADDR_W-1:0] pcu_addr_t;
endpackage

// *** hw/pcu_unit.sv ***
// One comparison unit: staged and active mode settings, its two counters.
// Assumes: period_end is a one-cycle pulse on aclk at each channel 0
// counter period end; wr_en comes from the bus slave in the same domain.
`timescale 1ns/1ps
`include "pcu_consts.svh"

module pcu_unit
	import pcu_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Staging write
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_strb,
	input  wire logic [31:0] wr_data,
	// Channel 0 period end
	input  wire logic        period_end,
	// Unit outputs
	output logic             act_en_reg,
	output logic             match_reg,
	output logic             update_reg,
	output logic             pending_reg
);
	pcu_field_t stg_trg_reg, stg_per_reg, stg_upr_reg;
	logic       stg_en_reg;
	pcu_field_t act_trg_reg, act_per_reg, act_upr_reg;
	pcu_field_t cpr_cnt_reg, upr_cnt_reg;
	pcu_field_t cpr_cnt_next, upr_cnt_next;
	logic       upd_now;
	logic       cmp_now;
	logic       cpr_wrap;

	// ------------------------------------------------------------------
	// Counters and update instant
	// ------------------------------------------------------------------
	// >= rather than == so a shrunken period cannot strand the counter
	assign cpr_wrap     = cpr_cnt_reg >= act_per_reg;
	assign upd_now      = period_end &&
	                      (upr_cnt_reg >= act_upr_reg);
	assign cmp_now      = period_end && act_en_reg &&
	                      (cpr_cnt_reg == act_trg_reg);
	assign cpr_cnt_next = !period_end ? cpr_cnt_reg :
	                      cpr_wrap ? `PCU_FIELD_RST :
	                      cpr_cnt_reg + 4'h1;
	assign upr_cnt_next = !period_end ? upr_cnt_reg :
	                      upd_now ? `PCU_FIELD_RST :
	                      upr_cnt_reg + 4'h1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpr_cnt_reg <= `PCU_FIELD_RST;
			upr_cnt_reg <= `PCU_FIELD_RST;
			match_reg   <= 1'b0;
			update_reg  <= 1'b0;
		end else begin
			cpr_cnt_reg <= cpr_cnt_next;
			upr_cnt_reg <= upr_cnt_next;
			match_reg   <= cmp_now;
			update_reg  <= upd_now;
		end
	end

	// ------------------------------------------------------------------
	// Staged copies: a write never touches the live settings
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stg_en_reg  <= 1'b0;
			stg_trg_reg <= `PCU_FIELD_RST;
			stg_per_reg <= `PCU_FIELD_RST;
			stg_upr_reg <= `PCU_FIELD_RST;
		end else if (wr_en) begin
			if (wr_strb[0]) begin
				stg_en_reg  <= wr_data[`PCU_EN_BIT];
				stg_trg_reg <= wr_data[`PCU_TRG_LSB +: `PCU_FIELD_W];
			end
			if (wr_strb[1]) begin
				stg_per_reg <= wr_data[`PCU_PER_LSB +: `PCU_FIELD_W];
			end
			if (wr_strb[2]) begin
				stg_upr_reg <= wr_data[`PCU_UPR_LSB +: `PCU_FIELD_W];
			end
		end
	end

	// ------------------------------------------------------------------
	// Active copies, loaded only at the update instant
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_en_reg  <= 1'b0;
			act_trg_reg <= `PCU_FIELD_RST;
			act_per_reg <= `PCU_FIELD_RST;
			act_upr_reg <= `PCU_FIELD_RST;
		end else if (upd_now) begin
			act_en_reg  <= stg_en_reg;
			act_trg_reg <= stg_trg_reg;
			act_per_reg <= stg_per_reg;
			act_upr_reg <= stg_upr_reg;
		end
	end

	// Set wins over the clear when a write meets an update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending_reg <= 1'b0;
		end else begin
			pending_reg <= wr_en | (pending_reg & ~upd_now);
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_STAGED_ONLY: assert property (
		wr_en && !upd_now |=> $stable(act_en_reg) && $stable(act_per_reg))
		else $error("Write changed live settings outside update");
	AST_UPD_LOADS: assert property (
		upd_now |=> update_reg && act_upr_reg == $past(stg_upr_reg)
		&& upr_cnt_reg == 4'h0)
		else $error("Update did not load staged settings");
	AST_NO_UPD_MIDWAY: assert property (
		period_end && upr_cnt_reg < act_upr_reg |=> !update_reg)
		else $error("Update before update period elapsed");
	AST_CPR_WRAP: assert property (
		period_end && cpr_cnt_reg >= act_per_reg |=> cpr_cnt_reg == 4'h0)
		else $error("Period counter did not wrap at maximum");
	AST_MATCH_AT_TRG: assert property (
		match_reg |-> $past(cpr_cnt_reg) == $past(act_trg_reg)
		&& $past(period_end))
		else $error("Comparison off the trigger count");
	AST_DISABLED: assert property (
		!act_en_reg |=> !match_reg)
		else $error("Disabled comparison matched");
	AST_ONCE_PER_WIN: assert property (
		match_reg && act_per_reg != 4'h0 && !update_reg |=>
		!match_reg)
		else $error("Two comparisons in one window");
	AST_HOLD_CNT: assert property (
		!period_end |=> $stable(cpr_cnt_reg) && $stable(upr_cnt_reg))
		else $error("Counter moved without period end");

	COV_MATCH:  cover property (match_reg);
	COV_UPDATE: cover property (update_reg && $past(pending_reg));
	COV_WR_UPD: cover property (wr_en && upd_now);
endmodule

// *** hw/pcu_update.sv ***
// Comparison-unit mode update block: AXI4-Lite slave and the units.
// Assumes: ch0_period_end is a one-cycle pulse from the PWM counter on
// aclk; one AXI4-Lite master; aresetn synchronous, active low.
`timescale 1ns/1ps
`include "pcu_consts.svh"

module pcu_update
	import pcu_pkg::*;
#(
	parameter int N_UNITS = `PCU_NUM_UNITS
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// Write address channel
	input  wire logic [8:0]           s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// Write data channel
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// Write response channel
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// Read address channel
	input  wire logic [8:0]           s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// Read data channel
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// PWM side
	input  wire logic                 ch0_period_end,
	output logic [N_UNITS-1:0]        compare_match,
	output logic [N_UNITS-1:0]        compare_update,
	output logic [N_UNITS-1:0]        compare_enable
);
	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Low two address bits are ignored: a byte offset hits its word
	// Returns {hit, index}; index is the unit number
	function automatic logic [3:0] unit_hit(input pcu_addr_t a);
		pcu_addr_t off;
		off = a - `PCU_MODE_UPD_BASE;
		unit_hit = {(a >= `PCU_MODE_UPD_BASE) && (off[3:2] == 2'h0)
		            && ({4'h0, off[8:4]} < 9'(N_UNITS)), off[6:4]};
	endfunction

	pcu_addr_t    aw_addr_reg;
	logic [31:0]  w_data_reg;
	logic [3:0]   w_strb_reg;
	logic         aw_full_reg, w_full_reg;
	logic         awready_reg, wready_reg, bvalid_reg;
	logic [1:0]   bresp_reg;
	logic         arready_reg, rvalid_reg;
	logic [1:0]   rresp_reg;
	logic [31:0]  rdata_reg;
	logic         aw_take, w_take, ar_take, do_write;
	logic         aw_full_next, w_full_next, rvalid_next;
	logic [3:0]   wr_dec, rd_dec;
	logic         rd_status;
	logic [31:0]  rd_word;
	logic [1:0]   rd_resp;
	logic [N_UNITS-1:0] unit_wr, pending, match_w, upd_w, en_w;

	assign aw_take      = s_axi_awvalid & awready_reg;
	assign w_take       = s_axi_wvalid & wready_reg;
	assign do_write     = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign aw_full_next = do_write ? 1'b0 : (aw_full_reg | aw_take);
	assign w_full_next  = do_write ? 1'b0 : (w_full_reg | w_take);
	assign wr_dec       = unit_hit(aw_addr_reg);
	assign ar_take      = s_axi_arvalid & arready_reg;
	assign rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);
	assign rd_dec       = unit_hit(s_axi_araddr);
	assign rd_status    = s_axi_araddr[8:2] == 7'(`PCU_STATUS_OFFSET >> 2);
	// Staging registers are write-only and read back as zero
	assign rd_word      = rd_status ? 32'(pending) : 32'h0000_0000;
	assign rd_resp      = (rd_status | rd_dec[3]) ? `PCU_RESP_OKAY :
	                      `PCU_RESP_SLVERR;

	// ------------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			aw_addr_reg <= 9'h000;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awready_reg <= ~aw_full_next;
			wready_reg  <= ~w_full_next;
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	// A write waits for a free response slot so no answer is lost;
	// the next address is refused in the meantime, as awready stays low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `PCU_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_dec[3] ? `PCU_RESP_OKAY : `PCU_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// arready mirrors the next rvalid: no read is taken while an answer
	// stands, at the cost of one dead cycle between reads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `PCU_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_resp;
			end
		end
	end

	// ------------------------------------------------------------------
	// Comparison units
	// ------------------------------------------------------------------
	// One data and strobe copy feeds every unit; only the decoded one loads
	for (genvar i = 0; i < N_UNITS; i++) begin : g_unit
		assign unit_wr[i] = do_write && wr_dec[3] &&
		                    (wr_dec[2:0] == 3'(i));
		pcu_unit u_unit (
			.aclk        (aclk),
			.aresetn     (aresetn),
			.wr_en       (unit_wr[i]),
			.wr_strb     (w_strb_reg[2:0]),
			.wr_data     (w_data_reg),
			.period_end  (ch0_period_end),
			.act_en_reg  (en_w[i]),
			.match_reg   (match_w[i]),
			.update_reg  (upd_w[i]),
			.pending_reg (pending[i])
		);
	end

	assign s_axi_awready  = awready_reg;
	assign s_axi_wready   = wready_reg;
	assign s_axi_bvalid   = bvalid_reg;
	assign s_axi_bresp    = bresp_reg;
	assign s_axi_arready  = arready_reg;
	assign s_axi_rvalid   = rvalid_reg;
	assign s_axi_rdata    = rdata_reg;
	assign s_axi_rresp    = rresp_reg;
	assign compare_match  = match_w;
	assign compare_update = upd_w;
	assign compare_enable = en_w;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	AST_UNIT_WRITE: assert property (
		@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr_reg == `PCU_MODE_UPD_BASE + 9'h010 |->
		unit_wr[1])
		else $error("Unit 1 staging write missed");
	AST_ONE_UNIT: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$onehot0(unit_wr))
		else $error("More than one unit written");
	AST_WO_READ: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ar_take && rd_dec[3] |=> rvalid_reg &&
		rdata_reg == 32'h0000_0000 && rresp_reg == `PCU_RESP_OKAY)
		else $error("Staging register read back data");
	AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid_reg && !s_axi_bready |=> bvalid_reg && $stable(bresp_reg))
		else $error("Write response dropped early");
	AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid_reg && !s_axi_rready |=> rvalid_reg && $stable(rdata_reg)
		&& $stable(rresp_reg))
		else $error("Read answer dropped early");
	AST_AW_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		aw_full_reg |-> !awready_reg)
		else $error("Address accepted while one is held");
	AST_W_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		w_full_reg |-> !wready_reg)
		else $error("Data accepted while one is held");
	AST_AR_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid_reg |-> !arready_reg)
		else $error("Read accepted while an answer stands");

	COV_WRITE_RESP: cover property (@(posedge aclk)
		bvalid_reg && s_axi_bready);
	COV_READ_STATUS: cover property (@(posedge aclk) ar_take && rd_status);
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the comparison-unit mode update block.
// Assumes: pcu_consts.svh on the include path; the bench drives the
// AXI4-Lite bus and the channel 0 period-end pulse itself.
`timescale 1ns/1ps
`include "pcu_consts.svh"

module tb_top;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [8:0]  awaddr  = 9'h000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic [3:0]  wstrb   = 4'h0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [8:0]  araddr  = 9'h000;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        pe      = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  compare_match, compare_update, compare_enable;
	int          errors    = 0;
	int          cmp_count = 0;
	// Expected per-pulse outputs for the unit set-up of test_stage
	logic [7:0]  exp_upd [8] = '{8'hFF, 8'hED, 8'hED, 8'hEF,
		8'hED, 8'hED, 8'hEF, 8'hED};
	logic [7:0]  exp_mt [8] = '{8'h00, 8'h01, 8'h01, 8'h03,
		8'h01, 8'h01, 8'h01, 8'h03};

	always #5 aclk = ~aclk;

	pcu_update #(.N_UNITS(8)) uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ch0_period_end(pe), .compare_match(compare_match),
		.compare_update(compare_update), .compare_enable(compare_enable)
	);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic timed_out();
		errors++;
		$display("[FAIL] bus wait expected answer seen none");
		give_verdict();
	endtask

	// Both channels offered together; each released once taken
	task automatic axi_wr(input logic [8:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
			if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		if (n >= 100) timed_out();
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [8:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		if (n >= 100) timed_out();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// One-cycle period end; outputs looked at once the answer edge landed
	task automatic pulse(output logic [7:0] upd, output logic [7:0] mt);
		@(posedge aclk);
		pe <= 1'b1;
		@(posedge aclk);
		pe <= 1'b0;
		#1;
		upd = compare_update;
		mt  = compare_match;
	endtask

	function automatic logic [8:0] unit_addr(input int x);
		return 9'(`PCU_MODE_UPD_BASE + x * `PCU_MODE_UPD_STRIDE);
	endfunction

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic test_map();
		logic [31:0] d;
		logic [1:0]  r;
		chk("enable after reset", compare_enable, 32'h0000_0000);
		axi_rd(unit_addr(7), d, r);
		chk("staging read resp", r, `PCU_RESP_OKAY);
		chk("staging read data", d, 32'h0000_0000);
		axi_rd(9'h100, d, r);
		chk("unmapped read resp", r, `PCU_RESP_SLVERR);
		axi_wr(9'h100, 32'hFFFF_FFFF, 4'hF, r);
		chk("unmapped write resp", r, `PCU_RESP_SLVERR);
		axi_rd(`PCU_STATUS_OFFSET, d, r);
		chk("pending after reset", d, 32'h0000_0000);
		$display("test test_map done");
	endtask

	task automatic test_stage();
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  upd, mt;
		axi_wr(unit_addr(0), 32'h0000_0001, 4'hF, r);
		chk("write resp unit0", r, `PCU_RESP_OKAY);
		axi_wr(unit_addr(1), 32'h0002_0321, 4'hF, r);
		axi_wr(unit_addr(2), 32'h0000_0000, 4'hF, r);
		// Enable byte left out: unit 4 must stay disabled
		axi_wr(unit_addr(4), 32'h000F_0F01, 4'hE, r);
		repeat (3) @(posedge aclk);
		#1;
		chk("enable before update", compare_enable, 32'h0);
		axi_rd(`PCU_STATUS_OFFSET, d, r);
		chk("pending staged", d, 32'h0000_0017);
		for (int i = 0; i < 8; i++) begin
			pulse(upd, mt);
			chk("update pulse", upd, exp_upd[i]);
			chk("match", mt, exp_mt[i]);
			chk("enable live", compare_enable, 32'h03);
		end
		axi_rd(`PCU_STATUS_OFFSET, d, r);
		chk("pending applied", d, 32'h0000_0000);
		$display("test test_stage done");
	endtask

	// Disable unit 1 mid-window; it must wait for its update instant
	task automatic test_midwin();
		logic [1:0] r;
		logic [7:0] upd, mt;
		axi_wr(unit_addr(1), 32'h0002_0320, 4'hF, r);
		pulse(upd, mt);
		chk("no early update", upd[1], 1'b0);
		chk("enable held", compare_enable[1], 1'b1);
		pulse(upd, mt);
		chk("update on wrap", upd[1], 1'b1);
		chk("enable dropped", compare_enable[1], 1'b0);
		$display("test test_midwin done");
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		test_map();
		test_stage();
		test_midwin();
		give_verdict();
	end
endmodule
